/* File: core/timer_pkg.sv */
// constants and register map for the match and capture timer
// Contract
// R1: five timers, each with a 32-bit count
// R2: 32-bit prescaler ahead of each counter
// R3: count system clock or external clock
// R4: four match values compared against count
// R5: match may interrupt while counting continues
// R6: stop-on-match halts the timer
// R7: reset-on-match clears the count
// R8: match writes go through shadow registers
// R9: match may issue a DMA request
// R10: four captures snapshot count on input transition
// R11: capture interrupt selectable per channel
// R12: match outputs driven low or high
// R13: output n follows match register n
// R14: prescaler wraps at limit, advancing counter
// R15: capture edge rising, falling or both
`default_nettype none
package timer_pkg;
    localparam int NUM_TIMERS_DEF = 5;
    localparam int NUM_CH         = 4;
    localparam int ADDR_W_DEF     = 12;
    localparam int TIMER_LSB      = 7;
    localparam int TIMER_W        = 3;
    localparam int WORD_LSB       = 2;
    localparam int WORD_W         = 5;

    localparam logic [4:0] REG_CTRL       = 5'h00;
    localparam logic [4:0] REG_PRE_LIMIT  = 5'h01;
    localparam logic [4:0] REG_PRE_COUNT  = 5'h02;
    localparam logic [4:0] REG_COUNT      = 5'h03;
    localparam logic [4:0] REG_MATCH_CTRL = 5'h04;
    localparam logic [4:0] REG_MATCH0     = 5'h05;
    localparam logic [4:0] REG_CAP_CTRL   = 5'h09;
    localparam logic [4:0] REG_CAP0       = 5'h0a;
    localparam logic [4:0] REG_OUT_CTRL   = 5'h0e;
    localparam logic [4:0] REG_INT_STATUS = 5'h0f;
    localparam logic [4:0] REG_INT_MASK   = 5'h10;

    localparam int CTRL_EN   = 0;
    localparam int CTRL_RST  = 1;
    localparam int CTRL_EXT  = 2;
    localparam int MC_INT    = 0;
    localparam int MC_RESET  = 4;
    localparam int MC_STOP   = 8;
    localparam int MC_DMA    = 12;
    localparam int CC_RISE   = 0;
    localparam int CC_FALL   = 4;
    localparam int CC_INT    = 8;
    localparam int ST_MATCH  = 0;
    localparam int ST_CAP    = 4;
    localparam int OUT_STATE = 8;

    localparam logic [1:0] OUT_NONE   = 2'h0;
    localparam logic [1:0] OUT_LOW    = 2'h1;
    localparam logic [1:0] OUT_HIGH   = 2'h2;
    localparam logic [1:0] OUT_TOGGLE = 2'h3;

    localparam logic [31:0] CTRL_WMASK  = 32'h0000_0007;
    localparam logic [31:0] MCTRL_WMASK = 32'h0000_ffff;
    localparam logic [31:0] CCTRL_WMASK = 32'h0000_0fff;
    localparam logic [31:0] OUT_WMASK   = 32'h0000_00ff;
    localparam logic [31:0] INT_WMASK   = 32'h0000_00ff;
    localparam logic [31:0] FULL_WMASK  = 32'hffff_ffff;
    localparam logic [31:0] REG_RESET   = 32'h0000_0000;
    localparam logic        OUT_RESET   = 1'b0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : timer_pkg
`default_nettype wire

/* File: core/match_capture_timer.sv */
// timer/counters with match, capture, match outputs and an AXI4-Lite register slave
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
module match_capture_timer
    import timer_pkg::*;
#(
    parameter int NUM_TIMERS = NUM_TIMERS_DEF,
    parameter int ADDR_W     = ADDR_W_DEF
) (
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic [ADDR_W-1:0]            awaddr,
    input  wire logic [2:0]                   awprot,
    input  wire logic                         awvalid,
    output logic                              awready,
    input  wire logic [31:0]                  wdata,
    input  wire logic [3:0]                   wstrb,
    input  wire logic                         wvalid,
    output logic                              wready,
    output logic [1:0]                        bresp,
    output logic                              bvalid,
    input  wire logic                         bready,
    input  wire logic [ADDR_W-1:0]            araddr,
    input  wire logic [2:0]                   arprot,
    input  wire logic                         arvalid,
    output logic                              arready,
    output logic [31:0]                       rdata,
    output logic [1:0]                        rresp,
    output logic                              rvalid,
    input  wire logic                         rready,
    input  wire logic [NUM_TIMERS-1:0]        ext_clk_in,
    input  wire logic [NUM_TIMERS*NUM_CH-1:0] capture_in,
    output logic [NUM_TIMERS*NUM_CH-1:0]      match_out,
    output logic [NUM_TIMERS*NUM_CH-1:0]      dma_req,
    output logic                              irq
);
    localparam int NM = NUM_TIMERS * NUM_CH;

    logic              awready_reg;
    logic              wready_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              arready_reg;
    logic              rvalid_reg;
    logic [31:0]       rdata_reg;
    logic [1:0]        rresp_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0]       w_data_reg;
    logic [3:0]        w_strb_reg;
    logic              irq_reg;

    logic [31:0] ctrl_reg      [NUM_TIMERS];
    logic [31:0] pre_lim_reg   [NUM_TIMERS];
    logic [31:0] pre_cnt_reg   [NUM_TIMERS];
    logic [31:0] count_reg     [NUM_TIMERS];
    logic [31:0] mctrl_reg     [NUM_TIMERS];
    logic [31:0] cctrl_reg     [NUM_TIMERS];
    logic [31:0] out_ctrl_reg  [NUM_TIMERS];
    logic [31:0] stat_reg      [NUM_TIMERS];
    logic [31:0] mask_reg      [NUM_TIMERS];
    logic [31:0] shadow_reg    [NM];
    logic [31:0] match_reg     [NM];
    logic [31:0] cap_reg       [NM];
    logic [NM-1:0]         mout_reg;
    logic [NM-1:0]         dma_reg;
    logic [NM-1:0]         cap_prev_reg;
    logic [NUM_TIMERS-1:0] ext_prev_reg;

    logic [NUM_TIMERS-1:0] run;
    logic [NUM_TIMERS-1:0] src_evt;
    logic [NUM_TIMERS-1:0] adv;
    logic [NUM_TIMERS-1:0] rst_hit;
    logic [NUM_TIMERS-1:0] stop_hit;
    logic [NUM_TIMERS-1:0] shadow_ld;
    logic [NUM_TIMERS-1:0] int_pend;
    logic [NM-1:0]         hit;
    logic [NM-1:0]         cap_evt;
    logic [31:0]           stat_set [NUM_TIMERS];
    logic [31:0]           w1c      [NUM_TIMERS];
    logic                  wr_fire;
    logic                  wr_ok;
    logic                  rd_ok;
    logic [TIMER_W-1:0]    wr_timer;
    logic [WORD_W-1:0]     wr_word;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [31:0] wmask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
        return (old & ~m) | (data & m);
    endfunction : merge

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        return (a[ADDR_W-1:TIMER_LSB+TIMER_W] == '0)
            && (int'(a[TIMER_LSB+:TIMER_W]) < NUM_TIMERS)
            && (a[WORD_LSB+:WORD_W] <= REG_INT_MASK);
    endfunction : addr_ok

    function automatic logic wsel(input int t, input int r);
        return wr_fire && wr_ok && (int'(wr_timer) == t) && (int'(wr_word) == r);
    endfunction : wsel

    function automatic logic [31:0] rd_value(input logic [ADDR_W-1:0] a);
        int          t;
        int          w;
        logic [31:0] v;
        t = int'(a[TIMER_LSB+:TIMER_W]);
        w = int'(a[WORD_LSB+:WORD_W]);
        v = REG_RESET;
        if (t < NUM_TIMERS) begin
            case (a[WORD_LSB+:WORD_W])
                REG_CTRL:       v = ctrl_reg[t];
                REG_PRE_LIMIT:  v = pre_lim_reg[t];
                REG_PRE_COUNT:  v = pre_cnt_reg[t];
                REG_COUNT:      v = count_reg[t];
                REG_MATCH_CTRL: v = mctrl_reg[t];
                REG_CAP_CTRL:   v = cctrl_reg[t];
                REG_OUT_CTRL:   v = out_ctrl_reg[t] | (32'(mout_reg[t*NUM_CH+:NUM_CH]) << OUT_STATE);
                REG_INT_STATUS: v = stat_reg[t];
                REG_INT_MASK:   v = mask_reg[t];
                default: begin
                    if (w >= int'(REG_MATCH0) && w < int'(REG_MATCH0) + NUM_CH) begin
                        v = shadow_reg[t*NUM_CH + w - int'(REG_MATCH0)];
                    end else if (w >= int'(REG_CAP0) && w < int'(REG_CAP0) + NUM_CH) begin
                        v = cap_reg[t*NUM_CH + w - int'(REG_CAP0)];
                    end
                end
            endcase
        end
        return v;
    endfunction : rd_value

    // bus decode
    assign wr_fire  = !awready_reg && !wready_reg && !bvalid_reg;
    assign wr_ok    = addr_ok(aw_addr_reg);
    assign rd_ok    = addr_ok(araddr);
    assign wr_timer = aw_addr_reg[TIMER_LSB+:TIMER_W];
    assign wr_word  = aw_addr_reg[WORD_LSB+:WORD_W];

    // per-timer event logic, one slice per instance
    for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer // R1
        assign run[t]     = ctrl_reg[t][CTRL_EN] & ~ctrl_reg[t][CTRL_RST];
        assign src_evt[t] = ctrl_reg[t][CTRL_EXT] ? (ext_clk_in[t] & ~ext_prev_reg[t]) : 1'b1; // R3
        assign adv[t]     = run[t] & src_evt[t] & (pre_cnt_reg[t] == pre_lim_reg[t]); // R2 R14
        for (genvar m = 0; m < NUM_CH; m++) begin : g_ch
            assign hit[t*NUM_CH+m] = adv[t] & (count_reg[t] == match_reg[t*NUM_CH+m]); // R4
            assign cap_evt[t*NUM_CH+m] =
                (cctrl_reg[t][CC_RISE+m] & capture_in[t*NUM_CH+m] & ~cap_prev_reg[t*NUM_CH+m])
              | (cctrl_reg[t][CC_FALL+m] & ~capture_in[t*NUM_CH+m] & cap_prev_reg[t*NUM_CH+m]); // R10 R15
        end
        assign rst_hit[t]   = |(hit[t*NUM_CH+:NUM_CH] & mctrl_reg[t][MC_RESET+:NUM_CH]); // R7
        assign stop_hit[t]  = |(hit[t*NUM_CH+:NUM_CH] & mctrl_reg[t][MC_STOP+:NUM_CH]); // R6
        assign shadow_ld[t] = rst_hit[t] | ~run[t]; // R8
        assign stat_set[t]  =
            (32'(hit[t*NUM_CH+:NUM_CH] & mctrl_reg[t][MC_INT+:NUM_CH]) << ST_MATCH) // R5
          | (32'(cap_evt[t*NUM_CH+:NUM_CH] & cctrl_reg[t][CC_INT+:NUM_CH]) << ST_CAP); // R11
        assign w1c[t]      = wsel(t, int'(REG_INT_STATUS))
                           ? merge(REG_RESET, w_data_reg, w_strb_reg, INT_WMASK) : REG_RESET;
        assign int_pend[t] = |(stat_reg[t] & mask_reg[t]);
    end

    // AXI4-Lite slave handshakes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= REG_RESET;
            rresp_reg   <= RESP_OKAY;
            aw_addr_reg <= '0;
            w_data_reg  <= REG_RESET;
            w_strb_reg  <= 4'h0;
        end else begin
            if (awvalid && awready_reg) begin
                aw_addr_reg <= awaddr;
                awready_reg <= 1'b0;
            end
            if (wvalid && wready_reg) begin
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
                wready_reg <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_reg && bready) begin
                bvalid_reg  <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end
            if (arvalid && arready_reg) begin
                arready_reg <= 1'b0;
                rvalid_reg  <= 1'b1;
                rdata_reg   <= rd_ok ? rd_value(araddr) : REG_RESET;
                rresp_reg   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_reg && rready) begin
                rvalid_reg  <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    // prescaler and main counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int t = 0; t < NUM_TIMERS; t++) begin
                pre_cnt_reg[t] <= REG_RESET;
                count_reg[t]   <= REG_RESET;
            end
            ext_prev_reg <= '0;
            cap_prev_reg <= '0;
        end else begin
            ext_prev_reg <= ext_clk_in;
            cap_prev_reg <= capture_in;
            for (int t = 0; t < NUM_TIMERS; t++) begin
                if (ctrl_reg[t][CTRL_RST]) begin
                    pre_cnt_reg[t] <= REG_RESET;
                    count_reg[t]   <= REG_RESET;
                end else if (run[t] && src_evt[t]) begin
                    pre_cnt_reg[t] <= adv[t] ? REG_RESET : pre_cnt_reg[t] + 32'h1; // R14
                    if (adv[t]) begin
                        count_reg[t] <= rst_hit[t] ? REG_RESET : count_reg[t] + 32'h1; // R5 R7
                    end
                end
            end
        end
    end

    // software-written configuration and match shadows
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int t = 0; t < NUM_TIMERS; t++) begin
                ctrl_reg[t]     <= REG_RESET;
                pre_lim_reg[t]  <= REG_RESET;
                mctrl_reg[t]    <= REG_RESET;
                cctrl_reg[t]    <= REG_RESET;
                out_ctrl_reg[t] <= REG_RESET;
                mask_reg[t]     <= REG_RESET;
            end
            for (int i = 0; i < NM; i++) begin
                shadow_reg[i] <= REG_RESET;
                match_reg[i]  <= REG_RESET;
            end
        end else begin
            for (int t = 0; t < NUM_TIMERS; t++) begin
                if (wsel(t, int'(REG_CTRL))) begin
                    ctrl_reg[t] <= merge(ctrl_reg[t], w_data_reg, w_strb_reg, CTRL_WMASK);
                end else if (stop_hit[t]) begin
                    ctrl_reg[t][CTRL_EN] <= 1'b0; // R6
                end
                if (wsel(t, int'(REG_PRE_LIMIT))) begin
                    pre_lim_reg[t] <= merge(pre_lim_reg[t], w_data_reg, w_strb_reg, FULL_WMASK);
                end
                if (wsel(t, int'(REG_MATCH_CTRL))) begin
                    mctrl_reg[t] <= merge(mctrl_reg[t], w_data_reg, w_strb_reg, MCTRL_WMASK);
                end
                if (wsel(t, int'(REG_CAP_CTRL))) begin
                    cctrl_reg[t] <= merge(cctrl_reg[t], w_data_reg, w_strb_reg, CCTRL_WMASK);
                end
                if (wsel(t, int'(REG_OUT_CTRL))) begin
                    out_ctrl_reg[t] <= merge(out_ctrl_reg[t], w_data_reg, w_strb_reg, OUT_WMASK);
                end
                if (wsel(t, int'(REG_INT_MASK))) begin
                    mask_reg[t] <= merge(mask_reg[t], w_data_reg, w_strb_reg, INT_WMASK);
                end
                for (int m = 0; m < NUM_CH; m++) begin
                    if (wsel(t, int'(REG_MATCH0) + m)) begin
                        shadow_reg[t*NUM_CH+m] <=
                            merge(shadow_reg[t*NUM_CH+m], w_data_reg, w_strb_reg, FULL_WMASK);
                    end
                    if (shadow_ld[t]) begin
                        match_reg[t*NUM_CH+m] <= shadow_reg[t*NUM_CH+m]; // R8
                    end
                end
            end
        end
    end

    // status, captures, match outputs, dma requests, interrupt
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int t = 0; t < NUM_TIMERS; t++) begin
                stat_reg[t] <= REG_RESET;
            end
            for (int i = 0; i < NM; i++) begin
                cap_reg[i] <= REG_RESET;
            end
            mout_reg <= {NM{OUT_RESET}};
            dma_reg  <= '0;
            irq_reg  <= 1'b0;
        end else begin
            irq_reg <= |int_pend;
            for (int t = 0; t < NUM_TIMERS; t++) begin
                // set wins over a same-cycle clear
                stat_reg[t] <= (stat_reg[t] & ~w1c[t]) | stat_set[t];
                for (int m = 0; m < NUM_CH; m++) begin
                    if (cap_evt[t*NUM_CH+m]) begin
                        cap_reg[t*NUM_CH+m] <= count_reg[t]; // R10
                    end
                    dma_reg[t*NUM_CH+m] <= hit[t*NUM_CH+m] & mctrl_reg[t][MC_DMA+m]; // R9
                    if (hit[t*NUM_CH+m]) begin // R13
                        case (out_ctrl_reg[t][2*m+:2]) // R12
                            OUT_LOW:    mout_reg[t*NUM_CH+m] <= 1'b0;
                            OUT_HIGH:   mout_reg[t*NUM_CH+m] <= 1'b1;
                            OUT_TOGGLE: mout_reg[t*NUM_CH+m] <= ~mout_reg[t*NUM_CH+m];
                            default:    mout_reg[t*NUM_CH+m] <= mout_reg[t*NUM_CH+m];
                        endcase
                    end
                end
            end
        end
    end

    assign awready   = awready_reg;
    assign wready    = wready_reg;
    assign bvalid    = bvalid_reg;
    assign bresp     = bresp_reg;
    assign arready   = arready_reg;
    assign rvalid    = rvalid_reg;
    assign rdata     = rdata_reg;
    assign rresp     = rresp_reg;
    assign match_out = mout_reg;
    assign dma_req   = dma_reg;
    assign irq       = irq_reg;
endmodule : match_capture_timer
`default_nettype wire

/* File: dv/timer_sva.sv */
// bus handshake checker for the match and capture timer
`default_nettype none
module timer_sva
    import timer_pkg::*;
#(
    parameter int NUM_TIMERS = NUM_TIMERS_DEF,
    parameter int ADDR_W     = ADDR_W_DEF
) (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic              awvalid,
    input wire logic              awready,
    input wire logic              wvalid,
    input wire logic              wready,
    input wire logic [1:0]        bresp,
    input wire logic              bvalid,
    input wire logic              bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic              arvalid,
    input wire logic              arready,
    input wire logic [31:0]       rdata,
    input wire logic [1:0]        rresp,
    input wire logic              rvalid,
    input wire logic              rready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_rd_taken;
        arvalid && arready;
    endsequence
    a_b_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    a_r_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read response dropped early");
    a_wr_refused: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    a_rd_refused: assert property (rvalid |-> !arready)
        else $error("read taken while response pending");
    a_rd_answer: assert property (s_rd_taken |=> rvalid)
        else $error("read answer late");
    a_wr_answer: assert property (s_wr_taken |=> !bvalid ##1 bvalid)
        else $error("write answer late");
    a_rd_unmapped: assert property (s_rd_taken and int'(araddr[9:7]) >= NUM_TIMERS
        |=> rresp == RESP_SLVERR && rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_wr_unmapped: assert property (s_wr_taken and awaddr[6:2] > REG_INT_MASK
        |=> ##1 bresp == RESP_SLVERR)
        else $error("unmapped write not refused");
endmodule : timer_sva
`default_nettype wire

/* File: dv/pin_partner.sv */
// pin-side partner: capture and external clock drivers
`default_nettype none
module pin_partner
    import timer_pkg::*;
#(
    parameter int NUM_TIMERS = NUM_TIMERS_DEF
) (
    input  wire logic                         aclk,
    output var logic [NUM_TIMERS-1:0]         ext_clk_in,
    output var logic [NUM_TIMERS*NUM_CH-1:0]  capture_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ext_clk_in = '0;
        capture_in = '0;
    end
    // idle low between bursts, one rising edge per pulse
    task automatic ext_pulses(input int t, input int k);
        repeat (k) begin
            @(posedge aclk);
            ext_clk_in[t] <= 1'b1;
            repeat (2) @(posedge aclk);
            ext_clk_in[t] <= 1'b0;
            @(posedge aclk);
        end
    endtask : ext_pulses
    task automatic cap_set(input logic [NUM_TIMERS*NUM_CH-1:0] v);
        @(posedge aclk);
        capture_in <= v;
        repeat (4) @(posedge aclk);
    endtask : cap_set
endmodule : pin_partner
`default_nettype wire

/* File: dv/match_capture_timer_tb.sv */
// self-checking bench for the match and capture timer
`default_nettype none
module match_capture_timer_tb
    import timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NT = NUM_TIMERS_DEF;
    localparam int AW = ADDR_W_DEF;
    logic               aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic               awready, wready, bvalid, arready, rvalid, irq;
    logic [AW-1:0]      awaddr, araddr;
    logic [31:0]        wdata, rdata, rd;
    logic [1:0]         bresp, rresp, resp;
    logic [NT-1:0]      ext_clk_in;
    logic [NT*4-1:0]    capture_in, match_out, dma_req;
    int                 err_count, cmp_count, cyc, dma_seen, p, m, k, n;

    match_capture_timer #(.NUM_TIMERS(NT), .ADDR_W(AW)) DUT (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .ext_clk_in(ext_clk_in), .capture_in(capture_in),
        .match_out(match_out), .dma_req(dma_req), .irq(irq));
    pin_partner #(.NUM_TIMERS(NT)) u_pins (
        .aclk(aclk), .ext_clk_in(ext_clk_in), .capture_in(capture_in));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (dma_req[2] === 1'b1) dma_seen++;
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end

    function automatic logic [AW-1:0] ra(input int t, input int idx);
        return AW'(t * 128 + 4 * idx);
    endfunction : ra
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wr(input int t, input int idx, input logic [31:0] d);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= ra(t, idx);
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rdr(input int t, input int idx);
        @(posedge aclk);
        araddr <= ra(t, idx);
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!(arvalid && arready));
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rdr
    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        void'($urandom(76));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values and unmapped places
        rdr(0, REG_COUNT);
        check("count_rst", rd, REG_RESET);
        rdr(0, REG_CTRL);
        check("ctrl_rst", rd, REG_RESET);
        rdr(0, 5'h11);
        check("rresp_gap", 32'(resp), 32'(RESP_SLVERR));
        rdr(NT, REG_CTRL);
        check("rresp_tmr", 32'(resp), 32'(RESP_SLVERR));
        wr(NT, REG_CTRL, 32'h1);
        check("bresp_tmr", 32'(resp), 32'(RESP_SLVERR));
        wr(0, 5'h11, 32'h1);
        check("bresp_gap", 32'(resp), 32'(RESP_SLVERR));
        // stop on match through a random prescale, with dma and irq
        p = $urandom % 4;
        m = $urandom % 8 + 1;
        wr(0, REG_PRE_LIMIT, p);
        wr(0, REG_MATCH0 + 2, m);
        wr(0, REG_MATCH_CTRL, 32'h0000_4404);
        wr(0, REG_INT_MASK, 32'h4);
        wr(0, REG_CTRL, 32'h1);
        n = 0;
        do begin
            rdr(0, REG_CTRL);
            n++;
        end while (rd[CTRL_EN] !== 1'b0 && n < 200);
        check("ctrl_stop", rd, 32'h0);
        rdr(0, REG_COUNT);
        check("count_stop", rd, m + 1);
        rdr(0, REG_PRE_COUNT);
        check("pre_wrap", rd, 32'h0);
        rdr(0, REG_PRE_LIMIT);
        check("pre_limit", rd, p);
        rdr(0, REG_MATCH0 + 2);
        check("match_rb", rd, m);
        rdr(0, REG_INT_STATUS);
        check("stat_match", rd, 32'h4);
        check("irq_on", 32'(irq), 32'h1);
        check("dma_cnt", dma_seen, 1);
        wr(0, REG_INT_STATUS, 32'h4);
        repeat (2) @(posedge aclk);
        check("irq_off", 32'(irq), 32'h0);
        // capture: channel 1 falling only, channel 3 rising only
        wr(0, REG_CAP_CTRL, 32'h0000_0a28);
        u_pins.cap_set(16'h000a);
        rdr(0, REG_INT_STATUS);
        check("stat_rise", rd, 32'h80);
        rdr(0, REG_CAP0 + 3);
        check("cap3", rd, m + 1);
        u_pins.cap_set(16'h0000);
        rdr(0, REG_INT_STATUS);
        check("stat_fall", rd, 32'ha0);
        rdr(0, REG_CAP0 + 1);
        check("cap1", rd, m + 1);
        check("irq_mask", 32'(irq), 32'h0);
        // reset on match driving output 1 of timer 3
        wr(3, REG_MATCH0 + 1, 32'h3);
        wr(3, REG_MATCH_CTRL, 32'h0000_0022);
        wr(3, REG_OUT_CTRL, 32'h8);
        wr(3, REG_CTRL, 32'h1);
        n = 0;
        while (match_out[13] !== 1'b1 && n < 100) begin
            @(posedge aclk);
            n++;
        end
        check("out_t3", 32'(match_out[15:12]), 32'h2);
        repeat (4) begin
            rdr(3, REG_COUNT);
            check("count_wrap", 32'(rd < 4), 32'h1);
        end
        rdr(3, REG_INT_STATUS);
        check("stat_t3", rd, 32'h2);
        wr(3, REG_OUT_CTRL, 32'h4);
        repeat (20) @(posedge aclk);
        check("out_low", 32'(match_out[13]), 32'h0);
        // external clock counting on timer 4
        k = $urandom % 5 + 3;
        wr(4, REG_OUT_CTRL, 32'hc0);
        wr(4, REG_CTRL, 32'h5);
        repeat (10) @(posedge aclk);
        u_pins.ext_pulses(4, k);
        repeat (4) @(posedge aclk);
        rdr(4, REG_COUNT);
        check("ext_count", rd, k);
        check("out_tgl", 32'(match_out[19:16]), 32'h8);
        final_report();
    end
endmodule : match_capture_timer_tb

bind match_capture_timer timer_sva #(.NUM_TIMERS(NUM_TIMERS), .ADDR_W(ADDR_W)) u_sva (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
`default_nettype wire
